// *** spi_master_slave_port_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_master_slave_port_tb;
   import spi_port_pkg::*;
   logic clk, reset, wait_m, stop_m, psel, penable, pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, dsck, dsck_oe, dmosi, dmosi_oe, dmiso, dmiso_oe, dss, dss_oe, irq;
   logic p_master, p_clock_polarity, p_clock_phase, p_lsb, p_sck, p_ss, p_data;
   logic [7:0] p_tx, p_rx;
   int n_mismatch = 0;
   int num_checks = 0;
   int toggles = 0;
   wire logic sck_w = dsck_oe ? dsck : p_sck;
   wire logic ss_w = dss_oe ? dss : p_ss;
   wire logic mosi_w = dmosi_oe ? dmosi : p_data;
   wire logic miso_w = dmiso_oe ? dmiso : p_data;

   spi_port dut (.i_sys_clk(clk), .i_reset(reset), .i_wait_mode(wait_m), .i_stop_mode(stop_m),
      .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_sck_clk(sck_w), .o_sck(dsck), .o_sck_oe(dsck_oe), .i_mosi(mosi_w), .o_mosi(dmosi),
      .o_mosi_oe(dmosi_oe), .i_miso(miso_w), .o_miso(dmiso), .o_miso_oe(dmiso_oe),
      .i_ss_n(ss_w), .o_ss_n(dss), .o_ss_n_oe(dss_oe), .o_irq(irq));

   spi_peer_model peer (.i_is_master(p_master), .i_clock_polarity(p_clock_polarity), .i_clock_phase(p_clock_phase),
      .i_lsb(p_lsb), .i_tx(p_tx), .i_sck(sck_w), .i_ss_n(ss_w), .i_mosi(mosi_w),
      .i_miso(miso_w), .o_sck(p_sck), .o_ss_n(p_ss), .o_data(p_data), .o_rx(p_rx));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(dsck) toggles++;

   // ****************************************
   // Bus and comparison tasks.
   // ****************************************
   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0000_00, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, ad(idx), d, r, e);
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp,
                         input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk(nm, r, exp);
      chk({nm, " err"}, {31'h0, e}, {31'h0, exp_err});
   endtask

   // Reading the flags with the full bit set also arms its clear by the data read.
   task automatic wait_rx();
      logic [31:0] r;
      logic e;
      int n;
      n = 0;
      do begin
         apb(1'b0, ad(IDX_FLAGS), 8'h00, r, e);
         n++;
      end while (r[FLAG_RX_FULL_BIT] !== 1'b1 && n < 300);
      chk("rx_full", {31'h0, r[FLAG_RX_FULL_BIT]}, 32'h0000_0001);
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #300000;
      n_mismatch++;
      summarize();
   end

   // ****************************************
   // Test sequence.
   // ****************************************
   initial begin
      int m;
      int t0;
      reset <= 1'b1;
      {wait_m, stop_m, psel, penable, pwrite} = 5'h00;
      {p_master, p_clock_polarity, p_clock_phase, p_lsb} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      p_tx = 8'h00;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      rd_chk("ctrl_one", ad(IDX_CTRL_ONE), 32'h0000_0000, 1'b0);
      rd_chk("ctrl_two", ad(IDX_CTRL_TWO), 32'h0000_0000, 1'b0);
      rd_chk("rate", ad(IDX_RATE), 32'h0000_0000, 1'b0);
      rd_chk("flags", ad(IDX_FLAGS), 32'h0000_0020, 1'b0);
      wr(IDX_CTRL_TWO, 8'hFF);
      rd_chk("ctrl_two mask", ad(IDX_CTRL_TWO), {24'h0000_00, CTRL_TWO_MASK}, 1'b0);
      wr(IDX_RATE, 8'hFF);
      rd_chk("rate mask", ad(IDX_RATE), {24'h0000_00, RATE_MASK}, 1'b0);
      wr(IDX_GAP_A, 8'hFF);
      rd_chk("gap a", ad(IDX_GAP_A), 32'h0000_0000, 1'b0);
      rd_chk("gap b", ad(IDX_GAP_B), 32'h0000_0000, 1'b0);
      rd_chk("gap c", ad(IDX_GAP_C), 32'h0000_0000, 1'b0);
      rd_chk("unmapped", 12'h3C0, 32'h0000_0000, 1'b1);
      rd_chk("misaligned", 12'h3A1, 32'h0000_0000, 1'b1);
      $display("test registers done");
      // A half period of three system cycles is the fastest the sampler allows.
      wr(IDX_CTRL_TWO, 8'h10);
      wr(IDX_RATE, 8'h20);
      for (m = 0; m < 8; m++) begin
         p_clock_polarity <= m[2];
         p_clock_phase <= m[1];
         p_lsb <= m[0];
         p_tx <= 8'h3C ^ m[7:0];
         wr(IDX_CTRL_ONE, {4'h5, m[2], m[1], 1'b1, m[0]});
         repeat (2) @(negedge clk);
         chk("sck idle", {31'h0, dsck}, {31'h0, m[2]});
         chk("ss oe", {31'h0, dss_oe}, 32'h0000_0001);
         wr(IDX_DATA, 8'hA5 ^ m[7:0]);
         wait_rx();
         rd_chk("master rx", ad(IDX_DATA), {24'h0000_00, 8'h3C ^ m[7:0]}, 1'b0);
         chk("peer rx", {24'h0000_00, p_rx}, {24'h0000_00, 8'hA5 ^ m[7:0]});
      end
      $display("test master modes done");
      wr(IDX_RATE, 8'h21);
      wr(IDX_CTRL_ONE, 8'h52);
      for (m = 0; m < 3; m++) begin
         p_tx <= 8'h96;
         {p_clock_polarity, p_clock_phase, p_lsb} <= 3'h0;
         wr(IDX_CTRL_TWO, (m == 1) ? 8'h12 : 8'h10);
         wr(IDX_DATA, 8'h69);
         repeat (30) @(posedge clk);
         stop_m <= (m == 0);
         wait_m <= (m != 0);
         repeat (8) @(posedge clk);
         t0 = toggles;
         repeat (30) @(posedge clk);
         chk("sck frozen", {31'h0, toggles == t0}, {31'h0, m != 2});
         stop_m <= 1'b0;
         wait_m <= 1'b0;
         wait_rx();
         rd_chk("resumed rx", ad(IDX_DATA), 32'h0000_0096, 1'b0);
         chk("resumed tx", {24'h0000_00, p_rx}, 32'h0000_0069);
      end
      $display("test low power done");
      wr(IDX_CTRL_TWO, 8'h11);
      repeat (2) @(negedge clk);
      chk("single wire off", {31'h0, dmosi_oe}, 32'h0000_0000);
      wr(IDX_CTRL_TWO, 8'h19);
      repeat (2) @(negedge clk);
      chk("single wire on", {31'h0, dmosi_oe}, 32'h0000_0001);
      wr(IDX_CTRL_TWO, 8'h10);
      wr(IDX_CTRL_ONE, 8'hD0);
      repeat (2) @(negedge clk);
      chk("ss oe off", {31'h0, dss_oe}, 32'h0000_0000);
      peer.hold_select(1'b0);
      repeat (6) @(negedge clk);
      chk("irq", {31'h0, irq}, 32'h0000_0001);
      rd_chk("fault flags", ad(IDX_FLAGS), 32'h0000_0030, 1'b0);
      rd_chk("master dropped", ad(IDX_CTRL_ONE), 32'h0000_00C0, 1'b0);
      peer.hold_select(1'b1);
      wr(IDX_CTRL_ONE, 8'h40);
      rd_chk("fault cleared", ad(IDX_FLAGS), 32'h0000_0020, 1'b0);
      $display("test mode fault done");
      p_master <= 1'b1;
      p_clock_phase <= 1'b1;
      p_tx <= 8'hC3;
      wr(IDX_CTRL_ONE, 8'h44);
      wr(IDX_DATA, 8'h5A);
      repeat (10) @(posedge clk);
      stop_m <= 1'b1;
      @(posedge clk);
      peer.run_frame();
      @(posedge clk);
      stop_m <= 1'b0;
      wait_rx();
      rd_chk("slave rx", ad(IDX_DATA), 32'h0000_00C3, 1'b0);
      chk("slave tx", {24'h0000_00, p_rx}, 32'h0000_005A);
      chk("slave sck oe", {31'h0, dsck_oe}, 32'h0000_0000);
      chk("slave mosi oe", {31'h0, dmosi_oe}, 32'h0000_0000);
      $display("test slave done");
      summarize();
   end
endmodule
`default_nettype wire

// *** spi_peer_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
   // Mode of the far side.
   input wire logic i_is_master,
   input wire logic i_clock_polarity,
   input wire logic i_clock_phase,
   input wire logic i_lsb,
   input wire logic [7:0] i_tx,
   // Resolved link wires.
   input wire logic i_sck,
   input wire logic i_ss_n,
   input wire logic i_mosi,
   input wire logic i_miso,
   // Driven lines and received byte.
   output logic o_sck,
   output logic o_ss_n,
   output logic o_data,
   output logic [7:0] o_rx
);
   int edges;
   int smp;
   logic [7:0] sh;
   wire logic din = i_is_master ? i_miso : i_mosi;

   function automatic int pos(input int s);
      return i_lsb ? s : 7 - s;
   endfunction

   initial begin
      o_sck = 1'b0;
      o_ss_n = 1'b1;
      o_data = 1'b0;
      o_rx = 8'h00;
      sh = 8'h00;
   end

   // Phase 0 puts the first bit out before any edge.
   always @(negedge i_ss_n) begin
      edges = 0;
      smp = 0;
      if (!i_clock_phase) begin
         o_data = i_tx[pos(0)];
      end
   end

   // Sampling edges take a bit, the other edges shift the next one out.
   always @(i_sck) begin
      if (i_ss_n === 1'b0) begin
         edges = edges + 1;
         if ((edges % 2 == 1) == !i_clock_phase) begin
            if (smp < 8) begin
               sh[pos(smp)] = din;
            end
            smp = smp + 1;
         end else if (smp < 8) begin
            o_data = i_tx[pos(smp)];
         end
      end
   end

   // A released line flips, so a stale bit can never pass for data.
   always @(posedge i_ss_n) begin
      o_rx = sh;
      o_data = ~o_data;
   end

   // The clock runs only inside a frame; it stands at its idle level otherwise.
   task automatic run_frame();
      o_sck = i_clock_polarity;
      #20 o_ss_n = 1'b0;
      // The slave drives its output only once the select has passed its synchroniser.
      #40;
      repeat (16) begin
         #3 o_sck = ~o_sck;
      end
      #20 o_ss_n = 1'b1;
   endtask

   task automatic hold_select(input logic v);
      o_ss_n = v;
   endtask
endmodule
`default_nettype wire

// *** spi_port.sv ***
// Operation
// - Full-duplex transfers, polled or interrupt driven.
// - Wait without halt bit behaves like run.
// - Wait with halt bit stops clock generation.
// - Master halts in stop, or in wait with halt bit; resumes after.
// - Slave keeps shifting during wait and stop.
// - Stop mode leaves the block otherwise active.
// - MOSI drives as master, samples as slave.
// - MISO drives as slave, samples as master.
// - Select is output as master, input as slave.
// - Master makes clock, slave uses pin clock.
// - Mode fault sets flag, may request interrupt.
// - Programmable polarity, phase and single-wire mode.
// - Polarity chooses idle level of clock.
// - Phase chooses odd or even sampling edges.
// - Bit order selectable, data register MSB fixed.
// - Select pin role follows fault and output enables.
`timescale 1ns/10ps
`default_nettype none
module spi_port
   import spi_port_pkg::*;
#(
   parameter int PADDR_W = 12
) (
   // ****************************************
   // System clock and reset.
   // ****************************************
   input wire logic i_sys_clk,
   input wire logic i_reset,
   // Low-power state of the processor.
   input wire logic i_wait_mode,
   input wire logic i_stop_mode,
   // APB slave.
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [PADDR_W-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Serial link pins.
   input wire logic i_sck_clk,
   output logic o_sck,
   output logic o_sck_oe,
   input wire logic i_mosi,
   output logic o_mosi,
   output logic o_mosi_oe,
   input wire logic i_miso,
   output logic o_miso,
   output logic o_miso_oe,
   input wire logic i_ss_n,
   output logic o_ss_n,
   output logic o_ss_n_oe,
   // Interrupt request.
   output logic o_irq
);

   // The upper address bits are decoded, so the bus must be wider than the map.
   if (PADDR_W < 11) begin : g_addr_width_check
      $error("PADDR_W must cover the register map");
   end

   // ****************************************
   // Registers and state.
   // ****************************************
   ctrl_one_t cr1;
   ctrl_two_t cr2;
   rate_sel_t rate;
   logic rx_full, tx_empty, fault, rx_armed, fault_armed;
   logic [7:0] rx_data, tx_buf, slave_tx;
   mst_state_t mst_state;
   logic [10:0] div_cnt;
   logic [3:0] edge_cnt;
   logic [7:0] tx_sh, rx_sh;
   logic [3:0] pin_s1, pin_s2;
   logic done_seen;

   // ****************************************
   // APB decode.
   // ****************************************
   wire [7:0] idx = i_paddr[9:2];
   wire addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[PADDR_W-1:10] == '0);
   wire mapped = addr_ok && (idx >= IDX_CTRL_ONE) && (idx <= IDX_GAP_C);
   wire first = i_psel && i_penable && !o_pready;
   wire commit = i_psel && i_penable && o_pready;
   wire wr = commit && i_pwrite;
   wire rd = commit && !i_pwrite;
   wire wr_cr1 = wr && addr_ok && idx == IDX_CTRL_ONE;
   wire wr_cr2 = wr && addr_ok && idx == IDX_CTRL_TWO;
   wire wr_rate = wr && addr_ok && idx == IDX_RATE;
   wire wr_data = wr && addr_ok && idx == IDX_DATA;
   wire rd_flags = rd && addr_ok && idx == IDX_FLAGS;
   wire rd_data = rd && addr_ok && idx == IDX_DATA;
   wire [7:0] flags = {rx_full, 1'b0, tx_empty, fault, 4'h0};
   wire [7:0] rd_byte = !addr_ok ? 8'h00 :
                        idx == IDX_CTRL_ONE ? cr1 :
                        idx == IDX_CTRL_TWO ? cr2 :
                        idx == IDX_RATE ? rate :
                        idx == IDX_FLAGS ? flags :
                        idx == IDX_DATA ? rx_data : 8'h00;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_pready <= 1'b0;
         o_prdata <= '0;
         o_pslverr <= 1'b0;
      end else begin
         o_pready <= first;
         o_prdata <= first ? {24'h00_0000, rd_byte} : '0;
         o_pslverr <= first && !mapped;
      end
   end

   // ****************************************
   // Pin synchronisers.
   // ****************************************
   // Order: done toggle, slave select, MOSI, MISO.
   logic done_tgl;
   wire [3:0] pin_raw = {done_tgl, i_ss_n, i_mosi, i_miso};
   always_ff @(posedge i_sys_clk) begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
   end
   wire done_s = pin_s2[3];
   wire ss_in_n = pin_s2[2];
   wire mosi_in = pin_s2[1];
   wire miso_in = pin_s2[0];

   // ****************************************
   // Mode control and faults.
   // ****************************************
   wire en = cr1.port_enable;
   wire is_master = en && cr1.master_select;
   wire is_slave = en && !cr1.master_select;
   // Slave logic ignores halt, since it must stay in step with the far master.
   wire halt = i_stop_mode || (i_wait_mode && cr2.halt_in_wait);
   wire ss_fault_in = cr2.fault_detect_enable && !cr1.select_output_enable;
   wire fault_hit = is_master && ss_fault_in && !ss_in_n;
   wire [7:0] cr1_new = i_pwdata[7:0];
   wire [7:0] cr2_new = i_pwdata[7:0] & CTRL_TWO_MASK;
   wire cr1_mode_chg = wr_cr1 && ((cr1_new & CTRL_ONE_MODE_MASK) != (cr1 & CTRL_ONE_MODE_MASK));
   wire cr2_mode_chg = wr_cr2 && cr1.master_select &&
                       ((cr2_new[4] != cr2.fault_detect_enable) ||
                        (cr2.single_wire_mode && cr2_new[3] != cr2.single_wire_output_enable));
   wire abort = cr1_mode_chg || cr2_mode_chg || fault_hit || !is_master;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         cr1 <= CTRL_ONE_RESET;
      end else if (fault_hit) begin
         cr1.master_select <= 1'b0;
      end else if (wr_cr1) begin
         cr1 <= cr1_new;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         cr2 <= CTRL_TWO_RESET;
         rate <= RATE_RESET;
      end else begin
         if (wr_cr2) cr2 <= cr2_new;
         if (wr_rate) rate <= i_pwdata[7:0] & RATE_MASK;
      end
   end

   // ****************************************
   // Master engine.
   // ****************************************
   // Half period is (prescale+1) << rate system cycles.
   wire [3:0] pre_plus = {1'b0, rate.prescale} + 4'h1;
   wire [10:0] div_last = ({7'h00, pre_plus} << rate.rate) - 11'h001;
   // Halt freezes divider and edge count, so the frame resumes where it stopped.
   wire tick = (mst_state == MST_SHIFT) && !halt && (div_cnt == div_last);
   wire sample_edge = edge_cnt[0] == cr1.clock_phase;
   wire shift_edge = !sample_edge && !(cr1.clock_phase && edge_cnt == 4'h0);
   wire mst_start = is_master && (mst_state == MST_IDLE) && !tx_empty && !abort;
   wire mst_done = tick && (edge_cnt == LAST_EDGE);
   wire mst_in = cr2.single_wire_mode ? mosi_in : miso_in;
   wire [7:0] rx_next = cr1.low_bit_first ? {mst_in, rx_sh[7:1]} : {rx_sh[6:0], mst_in};
   // Phase 0 ends on a shift edge, so the byte is already complete in rx_sh.
   wire [7:0] mst_byte = sample_edge ? rx_next : rx_sh;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset || abort) begin
         mst_state <= MST_IDLE;
         div_cnt <= '0;
         edge_cnt <= '0;
         o_sck <= cr1.clock_polarity;
      end else if (mst_state == MST_IDLE) begin
         o_sck <= cr1.clock_polarity;
         div_cnt <= '0;
         edge_cnt <= '0;
         if (mst_start) mst_state <= MST_SHIFT;
      end else if (!halt) begin
         div_cnt <= tick ? 11'h000 : div_cnt + 11'h001;
         if (tick) begin
            o_sck <= !o_sck;
            edge_cnt <= edge_cnt + 4'h1;
            if (mst_done) mst_state <= MST_IDLE;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         tx_sh <= '0;
         rx_sh <= '0;
      end else if (mst_start) begin
         tx_sh <= tx_buf;
      end else if (tick && sample_edge) begin
         rx_sh <= rx_next;
      end else if (tick && shift_edge) begin
         tx_sh <= cr1.low_bit_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
      end
   end

   // ****************************************
   // Slave engine on the link clock.
   // ****************************************
   // The pin clock is folded so that its rising edge always samples.
   // Configuration and slave_tx are held static while a frame runs, which
   // is why they cross without synchronisers.
   wire slave_clk = i_sck_clk ^ (cr1.clock_polarity ^ cr1.clock_phase);
   wire sl_in = cr2.single_wire_mode ? i_miso : i_mosi;
   logic [2:0] sl_cnt;
   logic [7:0] sl_sh;
   logic [7:0] sl_hold;

   // The link clock may stand still during reset, so sl_cnt and done_tgl clear from the
   // reset level itself; a defined toggle is what lets the system side see frames.
   always_ff @(posedge slave_clk or posedge i_reset) begin
      if (i_reset) begin
         sl_cnt <= '0;
         done_tgl <= 1'b0;
      end else if (i_ss_n) begin
         sl_cnt <= '0;
      end else begin
         sl_cnt <= sl_cnt + 3'h1;
         sl_sh <= cr1.low_bit_first ? {sl_in, sl_sh[7:1]} : {sl_sh[6:0], sl_in};
         if (sl_cnt == LAST_BIT) begin
            sl_hold <= cr1.low_bit_first ? {sl_in, sl_sh[7:1]} : {sl_sh[6:0], sl_in};
            done_tgl <= !done_tgl;
         end
      end
   end

   always_ff @(negedge slave_clk) begin
      o_miso <= cr1.low_bit_first ? slave_tx[sl_cnt] : slave_tx[LAST_BIT - sl_cnt];
   end

   // ****************************************
   // Status flags and data buffers.
   // ****************************************
   // A slave frame lands when the synchronised toggle changes.
   wire sl_done = is_slave && (done_s != done_seen);
   wire rx_set = mst_done || sl_done;
   wire [7:0] rx_in = mst_done ? mst_byte : sl_hold;
   wire tx_take = mst_start || (is_slave && !tx_empty && (sl_done || ss_in_n));
   wire rx_clr = rd_data && rx_armed;
   wire fault_clr = wr_cr1 && fault_armed;

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) done_seen <= 1'b0;
      else done_seen <= done_s;
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset || !en) begin
         rx_full <= 1'b0;
         tx_empty <= 1'b1;
         fault <= 1'b0;
         rx_armed <= 1'b0;
         fault_armed <= 1'b0;
      end else begin
         rx_full <= rx_set || (rx_full && !rx_clr);
         tx_empty <= tx_take || (tx_empty && !wr_data);
         fault <= fault_hit || (fault && !fault_clr);
         rx_armed <= rd_flags ? rx_full : (rx_armed && !rd_data);
         fault_armed <= rd_flags ? fault : (fault_armed && !wr_cr1);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         rx_data <= '0;
         tx_buf <= '0;
         slave_tx <= '0;
      end else begin
         if (rx_set) rx_data <= rx_in;
         if (wr_data && tx_empty) tx_buf <= i_pwdata[7:0];
         if (tx_take && is_slave) slave_tx <= tx_buf;
      end
   end

   // ****************************************
   // Pin drivers and interrupt.
   // ****************************************
   wire next_mosi_oe = is_master && (!cr2.single_wire_mode || cr2.single_wire_output_enable);
   wire next_miso_oe = is_slave && !ss_in_n &&
                       (!cr2.single_wire_mode || cr2.single_wire_output_enable);
   wire ss_drive = is_master && cr2.fault_detect_enable && cr1.select_output_enable;
   wire next_mosi = cr1.low_bit_first ? tx_sh[0] : tx_sh[7];
   wire next_irq = (cr1.fault_rx_irq_enable && (rx_full || fault)) ||
                   (cr1.tx_empty_irq_enable && tx_empty);

   always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
         o_sck_oe <= 1'b0;
         o_mosi <= 1'b0;
         o_mosi_oe <= 1'b0;
         o_miso_oe <= 1'b0;
         o_ss_n <= 1'b1;
         o_ss_n_oe <= 1'b0;
         o_irq <= 1'b0;
      end else begin
         o_sck_oe <= is_master;
         o_mosi <= next_mosi;
         o_mosi_oe <= next_mosi_oe;
         o_miso_oe <= next_miso_oe;
         // Select falls with the start so that the two-flop sampler sees the first bit.
         o_ss_n <= !(mst_start || mst_state == MST_SHIFT);
         o_ss_n_oe <= ss_drive;
         o_irq <= next_irq;
      end
   end

   // ****************************************
   // Assertions.
   // ****************************************
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_reset);

   AST_START_FREES_BUFFER: assert property (mst_start |=> tx_empty)
      else $error("buffer not freed at master start");
   AST_DONE_FILLS_RX: assert property (mst_done |=> rx_full && rx_data == rx_sh)
      else $error("received byte not stored");
   AST_HALT_FREEZES: assert property (mst_state == MST_SHIFT && halt && !abort
      |=> $stable(edge_cnt) && $stable(o_sck))
      else $error("master moved while halted");
   AST_WAIT_NO_CLOCK: assert property (i_wait_mode && cr2.halt_in_wait && !abort
      |=> $stable(o_sck))
      else $error("clock generated in halted wait");
   AST_WAIT_RUNS: assert property (i_wait_mode && !i_stop_mode && !cr2.halt_in_wait && tick
      && !abort |=> o_sck != $past(o_sck))
      else $error("clock stopped in plain wait");
   AST_MOSI_ROLE: assert property (o_mosi_oe |-> $past(is_master))
      else $error("MOSI driven while not master");
   AST_MISO_ROLE: assert property (o_miso_oe |-> $past(is_slave) && !$past(ss_in_n))
      else $error("MISO driven while not selected slave");
   AST_SELECT_ROLE: assert property (o_ss_n_oe == $past(ss_drive))
      else $error("select pin role wrong");
   AST_IDLE_LEVEL: assert property (mst_state == MST_IDLE ##1 mst_state == MST_IDLE
      && $stable(cr1.clock_polarity) |-> o_sck == cr1.clock_polarity)
      else $error("clock idle level wrong");
   AST_FAULT_SETS: assert property (fault_hit |=> fault && !cr1.master_select)
      else $error("mode fault not recorded");
   AST_RESERVED_ZERO: assert property (wr_cr2 |=> (cr2 & ~CTRL_TWO_MASK) == 8'h00)
      else $error("reserved control bits stored");

   COV_MASTER_BYTE: cover property (mst_start ##[1:1000] mst_done);
   COV_SLAVE_BYTE: cover property (sl_done);
   COV_FAULT: cover property (fault_hit);
   COV_HALTED: cover property (mst_state == MST_SHIFT && halt);
   COV_PLAIN_WAIT: cover property (i_wait_mode && !cr2.halt_in_wait && tick);

endmodule
`default_nettype wire

// *** spi_port_pkg.sv ***
`default_nettype none
package spi_port_pkg;

   // ****************************************
   // Register map, kept as word indices.
   // ****************************************
   localparam logic [7:0] IDX_CTRL_ONE = 8'hE8;
   localparam logic [7:0] IDX_CTRL_TWO = 8'hE9;
   localparam logic [7:0] IDX_RATE = 8'hEA;
   localparam logic [7:0] IDX_FLAGS = 8'hEB;
   localparam logic [7:0] IDX_GAP_A = 8'hEC;
   localparam logic [7:0] IDX_DATA = 8'hED;
   localparam logic [7:0] IDX_GAP_B = 8'hEE;
   localparam logic [7:0] IDX_GAP_C = 8'hEF;

   // ****************************************
   // Reset values and writable masks.
   // ****************************************
   localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
   localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
   localparam logic [7:0] RATE_RESET = 8'h00;
   localparam logic [7:0] CTRL_TWO_MASK = 8'h1B;
   localparam logic [7:0] RATE_MASK = 8'h77;
   localparam logic [7:0] CTRL_ONE_MODE_MASK = 8'h1F;

   // ****************************************
   // Flag positions and frame geometry.
   // ****************************************
   localparam int FLAG_RX_FULL_BIT = 7;
   localparam int FLAG_TX_EMPTY_BIT = 5;
   localparam int FLAG_FAULT_BIT = 4;
   localparam logic [3:0] LAST_EDGE = 4'hF;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // ****************************************
   // Carriers.
   // ****************************************
   typedef struct packed {
      logic fault_rx_irq_enable;
      logic port_enable;
      logic tx_empty_irq_enable;
      logic master_select;
      logic clock_polarity;
      logic clock_phase;
      logic select_output_enable;
      logic low_bit_first;
   } ctrl_one_t;

   typedef struct packed {
      logic [2:0] zero_hi;
      logic fault_detect_enable;
      logic single_wire_output_enable;
      logic zero_lo;
      logic halt_in_wait;
      logic single_wire_mode;
   } ctrl_two_t;

   typedef struct packed {
      logic zero_hi;
      logic [2:0] prescale;
      logic zero_lo;
      logic [2:0] rate;
   } rate_sel_t;

   typedef enum logic {MST_IDLE, MST_SHIFT} mst_state_t;

endpackage
`default_nettype wire
